// [core/dbc_consts.svh]
// constants for the disk buffer cache and prefetch controller
`ifndef DBC_CONSTS_SVH
`define DBC_CONSTS_SVH
// buffer geometry
`define DBC_PHYS_MBYTES 16
`define DBC_USABLE_KB 13000
`define DBC_BLK_BYTES 512
`define DBC_NSEG 8
`define DBC_PF_BLKS 16'h0040
// register byte offsets
`define DBC_OFS_CTRL 8'h00
`define DBC_OFS_STATUS 8'h04
`define DBC_OFS_SEGSIZE 8'h08
`define DBC_OFS_CHITS 8'h0c
`define DBC_OFS_PHITS 8'h10
`define DBC_OFS_CLEAR 8'h14
// control bit positions
`define DBC_CTL_RCD 0
`define DBC_CTL_WCE 1
`define DBC_CTL_RAD 2
`define DBC_CTL_PCA 3
// status bit positions
`define DBC_ST_DEFER 0
`define DBC_ST_REJECT 1
`define DBC_ST_BUSY 2
`define DBC_ST_PFON 3
`define DBC_ST_DIRTY 4
// fixed values
`define DBC_SEGSIZE_RPT 16'hffff
`define DBC_CTRL_RST 4'h0
`define DBC_STAT_GOOD 1'h0
`define DBC_STAT_CHECK 1'h1
`define DBC_SEQ_ON 2'h2
`define DBC_SEQ_MAX 2'h3
`endif

// [core/dbc_pkg.sv]
// types for the disk buffer cache and prefetch controller
package dbc_pkg;
    typedef enum logic [1:0] {
        DBC_CMD_READ = 2'b00,
        DBC_CMD_WRITE = 2'b01,
        DBC_CMD_SYNC = 2'b10
    } dbc_cmd_e;
    typedef enum logic [2:0] {
        DBC_ST_IDLE = 3'b000,
        DBC_ST_LOOKUP = 3'b001,
        DBC_ST_MED_RD = 3'b010,
        DBC_ST_XFER_RD = 3'b011,
        DBC_ST_PREFETCH = 3'b100,
        DBC_ST_XFER_WR = 3'b101,
        DBC_ST_MED_WR = 3'b110,
        DBC_ST_SYNC = 3'b111
    } dbc_state_e;
endpackage

// [core/dbc_cache_ctrl.sv]
// segmented buffer cache and adaptive prefetch controller
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "dbc_consts.svh"
module dbc_cache_ctrl #(
    parameter int NSEG = `DBC_NSEG,
    parameter logic [15:0] SEG_BLKS = 16'(`DBC_USABLE_KB * 1024 / `DBC_BLK_BYTES / `DBC_NSEG),
    parameter logic [15:0] PF_BLKS = `DBC_PF_BLKS
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // host command port
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd_op,
    input wire logic [31:0] i_cmd_lba,
    input wire logic [15:0] i_cmd_len,
    output logic o_cmd_ready,
    output logic o_cmd_done,
    output logic o_cmd_status,
    // medium access
    output logic o_med_req,
    output logic o_med_wr,
    output logic [31:0] o_med_lba,
    output logic [15:0] o_med_len,
    output logic [2:0] o_med_seg,
    input wire logic i_med_done,
    input wire logic i_med_err,
    // host data transfer
    output logic o_xfer_req,
    output logic o_xfer_to_host,
    output logic [2:0] o_xfer_seg,
    output logic [15:0] o_xfer_len,
    input wire logic i_xfer_ratio_ok,
    input wire logic i_xfer_done,
    // status pins
    output logic o_deferred_err
);
    localparam int SW = $clog2(NSEG);

    function automatic logic covers(input logic [31:0] slba, input logic [15:0] scnt,
                                    input logic [31:0] lba, input logic [15:0] len);
        covers = (lba >= slba) && ({1'b0, lba} + {17'h0, len} <= {1'b0, slba} + {17'h0, scnt});
    endfunction

    function automatic logic overlaps(input logic [31:0] slba, input logic [15:0] scnt,
                                      input logic [31:0] lba, input logic [15:0] len);
        overlaps = ({1'b0, lba} < {1'b0, slba} + {17'h0, scnt}) &&
                   ({1'b0, slba} < {1'b0, lba} + {17'h0, len});
    endfunction

    // segment tag table
    logic seg_vld_r [NSEG];
    logic seg_dirty_r [NSEG];
    logic seg_pf_r [NSEG];
    logic [31:0] seg_lba_r [NSEG];
    logic [15:0] seg_cnt_r [NSEG];
    logic [15:0] seg_age_r [NSEG];

    // control and state
    dbc_pkg::dbc_state_e state_r;
    dbc_pkg::dbc_cmd_e op_r;
    logic [3:0] ctrl_r;
    logic defer_r;
    logic reject_r;
    logic [31:0] cur_lba_r;
    logic [15:0] rem_r;
    logic [15:0] chunk_r;
    logic [SW-1:0] sel_r;
    logic good_sent_r;
    logic [15:0] stamp_r;
    logic [1:0] seq_r;
    logic [31:0] last_end_r;
    logic [15:0] chits_r;
    logic [15:0] phits_r;

    // named decodes
    wire read_cache_disable = ctrl_r[`DBC_CTL_RCD];
    wire write_cache_enable = ctrl_r[`DBC_CTL_WCE];
    wire rad = ctrl_r[`DBC_CTL_RAD];
    wire pca = ctrl_r[`DBC_CTL_PCA];
    wire wr_ctrl = i_wr && (i_addr == `DBC_OFS_CTRL);
    wire wr_seg = i_wr && (i_addr == `DBC_OFS_SEGSIZE);
    wire wr_clr = i_wr && (i_addr == `DBC_OFS_CLEAR);
    wire pf_go = !rad && (seq_r >= `DBC_SEQ_ON);
    wire [15:0] chunk_first = (i_cmd_len < SEG_BLKS) ? i_cmd_len : SEG_BLKS;
    wire [15:0] rem_after = rem_r - chunk_r;
    wire [15:0] chunk_next = (rem_after < SEG_BLKS) ? rem_after : SEG_BLKS;
    wire [31:0] lba_after = cur_lba_r + {16'h0, chunk_r};
    wire [31:0] req_end = cur_lba_r + {16'h0, rem_r};
    wire seq_hit = (cur_lba_r == last_end_r);

    // hit search, dirty summary and reclaim choice
    logic hit_any;
    logic [SW-1:0] hit_idx;
    logic any_dirty;
    logic free_any;
    logic [SW-1:0] free_idx;
    logic [SW-1:0] lru_idx;
    logic [15:0] lru_age;
    always_comb begin
        hit_any = 1'b0;
        hit_idx = '0;
        any_dirty = 1'b0;
        free_any = 1'b0;
        free_idx = '0;
        lru_idx = '0;
        lru_age = 16'hffff;
        for (int i = 0; i < NSEG; i++) begin
            // cache disabled: only prefetched data may hit
            if (seg_vld_r[i] && (!read_cache_disable || seg_pf_r[i]) &&
                covers(seg_lba_r[i], seg_cnt_r[i], cur_lba_r, rem_r) && !hit_any) begin
                hit_any = 1'b1;
                hit_idx = SW'(i);
            end
            any_dirty = any_dirty | seg_dirty_r[i];
            if (!seg_vld_r[i] && !seg_dirty_r[i] && !free_any) begin
                free_any = 1'b1;
                free_idx = SW'(i);
            end
            if (!seg_dirty_r[i] && (seg_age_r[i] < lru_age)) begin
                lru_age = seg_age_r[i];
                lru_idx = SW'(i);
            end
        end
    end
    wire [SW-1:0] victim = free_any ? free_idx : lru_idx;

    // register read mux, segment size fixed at all ones
    logic [31:0] rd_mux;
    assign rd_mux =
        (i_addr == `DBC_OFS_CTRL) ? {28'h0, ctrl_r} :
        (i_addr == `DBC_OFS_STATUS) ? {27'h0, any_dirty, pf_go,
                                       state_r != dbc_pkg::DBC_ST_IDLE, reject_r, defer_r} :
        (i_addr == `DBC_OFS_SEGSIZE) ? {16'h0, `DBC_SEGSIZE_RPT} :
        (i_addr == `DBC_OFS_CHITS) ? {16'h0, chits_r} :
        (i_addr == `DBC_OFS_PHITS) ? {16'h0, phits_r} : 32'h0;

    // register file; set wins over clear
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 32'h0;
            ctrl_r <= `DBC_CTRL_RST;
            reject_r <= 1'b0;
        end else begin
            o_rdata <= i_rd ? rd_mux : 32'h0;
            // all four feature bits written together from i_wdata[3:0]
            if (wr_ctrl) begin
                ctrl_r <= i_wdata[3:0];
            end
            // size write never changes segmentation
            if (wr_seg && pca) begin
                reject_r <= 1'b1;
            end else if (wr_clr && i_wdata[`DBC_ST_REJECT]) begin
                reject_r <= 1'b0;
            end
        end
    end

    // command sequencer and segment table
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= dbc_pkg::DBC_ST_IDLE;
            op_r <= dbc_pkg::DBC_CMD_READ;
            defer_r <= 1'b0;
            cur_lba_r <= 32'h0;
            rem_r <= 16'h0;
            chunk_r <= 16'h0;
            sel_r <= '0;
            good_sent_r <= 1'b0;
            stamp_r <= 16'h0;
            seq_r <= 2'h0;
            last_end_r <= 32'h0;
            chits_r <= 16'h0;
            phits_r <= 16'h0;
            o_cmd_ready <= 1'b0;
            o_cmd_done <= 1'b0;
            o_cmd_status <= `DBC_STAT_GOOD;
            o_med_req <= 1'b0;
            o_med_wr <= 1'b0;
            o_med_lba <= 32'h0;
            o_med_len <= 16'h0;
            o_med_seg <= 3'h0;
            o_xfer_req <= 1'b0;
            o_xfer_to_host <= 1'b0;
            o_xfer_seg <= 3'h0;
            o_xfer_len <= 16'h0;
            o_deferred_err <= 1'b0;
            for (int i = 0; i < NSEG; i++) begin
                seg_vld_r[i] <= 1'b0;
                seg_dirty_r[i] <= 1'b0;
                seg_pf_r[i] <= 1'b0;
                seg_lba_r[i] <= 32'h0;
                seg_cnt_r[i] <= 16'h0;
                seg_age_r[i] <= 16'h0;
            end
        end else begin
            o_cmd_done <= 1'b0;
            o_deferred_err <= defer_r;
            if (wr_clr && i_wdata[`DBC_ST_DEFER]) begin
                defer_r <= 1'b0;
            end
            case (state_r)
                dbc_pkg::DBC_ST_IDLE: begin
                    o_cmd_ready <= 1'b1;
                    if (i_cmd_valid && o_cmd_ready) begin
                        o_cmd_ready <= 1'b0;
                        op_r <= dbc_pkg::dbc_cmd_e'(i_cmd_op);
                        cur_lba_r <= i_cmd_lba;
                        rem_r <= i_cmd_len;
                        chunk_r <= chunk_first;
                        good_sent_r <= 1'b0;
                        stamp_r <= stamp_r + 16'h1;
                        state_r <= (i_cmd_op == dbc_pkg::DBC_CMD_SYNC) ?
                                   dbc_pkg::DBC_ST_SYNC : dbc_pkg::DBC_ST_LOOKUP;
                    end
                end
                dbc_pkg::DBC_ST_LOOKUP: begin
                    if (op_r == dbc_pkg::DBC_CMD_READ) begin
                        // sequential streams train the prefetch predictor
                        if (seq_hit && seq_r != `DBC_SEQ_MAX) begin
                            seq_r <= seq_r + 2'h1;
                        end else if (!seq_hit && seq_r != 2'h0) begin
                            seq_r <= seq_r - 2'h1;
                        end
                        last_end_r <= req_end;
                        if (hit_any) begin
                            sel_r <= hit_idx;
                            seg_age_r[hit_idx] <= stamp_r;
                            if (seg_pf_r[hit_idx]) begin
                                phits_r <= phits_r + 16'h1;
                            end else begin
                                chits_r <= chits_r + 16'h1;
                            end
                            chunk_r <= rem_r;
                            o_xfer_seg <= 3'(hit_idx);
                            o_xfer_len <= rem_r;
                            o_xfer_to_host <= 1'b1;
                            state_r <= dbc_pkg::DBC_ST_XFER_RD;
                        end else begin
                            sel_r <= victim;
                            seg_vld_r[victim] <= 1'b0;
                            seg_pf_r[victim] <= 1'b0;
                            seg_age_r[victim] <= stamp_r;
                            o_med_req <= 1'b1;
                            o_med_wr <= 1'b0;
                            o_med_lba <= cur_lba_r;
                            o_med_len <= chunk_r;
                            o_med_seg <= 3'(victim);
                            state_r <= dbc_pkg::DBC_ST_MED_RD;
                        end
                    end else begin
                        // stale copies dropped even with cache off, so no old data can hit
                        for (int i = 0; i < NSEG; i++) begin
                            if (overlaps(seg_lba_r[i], seg_cnt_r[i], cur_lba_r, rem_r)) begin
                                seg_vld_r[i] <= 1'b0;
                            end
                        end
                        sel_r <= victim;
                        seg_vld_r[victim] <= 1'b0;
                        seg_pf_r[victim] <= 1'b0;
                        seg_age_r[victim] <= stamp_r;
                        o_xfer_seg <= 3'(victim);
                        o_xfer_len <= chunk_r;
                        o_xfer_to_host <= 1'b0;
                        state_r <= dbc_pkg::DBC_ST_XFER_WR;
                    end
                end
                dbc_pkg::DBC_ST_MED_RD: begin
                    if (i_med_done) begin
                        o_med_req <= 1'b0;
                        if (i_med_err) begin
                            o_cmd_done <= 1'b1;
                            o_cmd_status <= `DBC_STAT_CHECK;
                            state_r <= dbc_pkg::DBC_ST_IDLE;
                        end else begin
                            seg_lba_r[sel_r] <= cur_lba_r;
                            seg_cnt_r[sel_r] <= chunk_r;
                            seg_vld_r[sel_r] <= !read_cache_disable;
                            o_xfer_seg <= 3'(sel_r);
                            o_xfer_len <= chunk_r;
                            o_xfer_to_host <= 1'b1;
                            state_r <= dbc_pkg::DBC_ST_XFER_RD;
                        end
                    end
                end
                dbc_pkg::DBC_ST_XFER_RD: begin
                    if (!o_xfer_req && i_xfer_ratio_ok) begin
                        o_xfer_req <= 1'b1;
                    end
                    if (o_xfer_req && i_xfer_done) begin
                        o_xfer_req <= 1'b0;
                        rem_r <= rem_after;
                        cur_lba_r <= lba_after;
                        chunk_r <= chunk_next;
                        if (rem_after == 16'h0) begin
                            o_cmd_done <= 1'b1;
                            o_cmd_status <= `DBC_STAT_GOOD;
                            // look-ahead sized by our own constant only
                            if (pf_go) begin
                                o_med_req <= 1'b1;
                                o_med_wr <= 1'b0;
                                o_med_lba <= lba_after;
                                o_med_len <= PF_BLKS;
                                o_med_seg <= 3'(sel_r);
                                state_r <= dbc_pkg::DBC_ST_PREFETCH;
                            end else begin
                                state_r <= dbc_pkg::DBC_ST_IDLE;
                            end
                        end else begin
                            o_med_req <= 1'b1;
                            o_med_wr <= 1'b0;
                            o_med_lba <= lba_after;
                            o_med_len <= chunk_next;
                            o_med_seg <= 3'(sel_r);
                            state_r <= dbc_pkg::DBC_ST_MED_RD;
                        end
                    end
                end
                dbc_pkg::DBC_ST_PREFETCH: begin
                    if (i_med_done) begin
                        o_med_req <= 1'b0;
                        if (!i_med_err) begin
                            seg_lba_r[sel_r] <= o_med_lba;
                            seg_cnt_r[sel_r] <= PF_BLKS;
                            seg_pf_r[sel_r] <= 1'b1;
                            seg_vld_r[sel_r] <= 1'b1;
                        end
                        state_r <= dbc_pkg::DBC_ST_IDLE;
                    end
                end
                dbc_pkg::DBC_ST_XFER_WR: begin
                    if (!o_xfer_req && i_xfer_ratio_ok) begin
                        o_xfer_req <= 1'b1;
                    end
                    if (o_xfer_req && i_xfer_done) begin
                        o_xfer_req <= 1'b0;
                        seg_lba_r[sel_r] <= cur_lba_r;
                        seg_cnt_r[sel_r] <= chunk_r;
                        seg_dirty_r[sel_r] <= 1'b1;
                        if (rem_after == 16'h0 && write_cache_enable) begin
                            o_cmd_done <= 1'b1;
                            o_cmd_status <= `DBC_STAT_GOOD;
                            good_sent_r <= 1'b1;
                        end
                        o_med_req <= 1'b1;
                        o_med_wr <= 1'b1;
                        o_med_lba <= cur_lba_r;
                        o_med_len <= chunk_r;
                        o_med_seg <= 3'(sel_r);
                        state_r <= dbc_pkg::DBC_ST_MED_WR;
                    end
                end
                dbc_pkg::DBC_ST_MED_WR: begin
                    if (i_med_done) begin
                        o_med_req <= 1'b0;
                        seg_dirty_r[sel_r] <= 1'b0;
                        // same segments serve later reads only with read cache enabled and no medium error
                        seg_vld_r[sel_r] <= !read_cache_disable && !i_med_err;
                        if (i_med_err) begin
                            if (good_sent_r) begin
                                defer_r <= 1'b1;
                            end else begin
                                o_cmd_done <= 1'b1;
                                o_cmd_status <= `DBC_STAT_CHECK;
                            end
                            state_r <= dbc_pkg::DBC_ST_IDLE;
                        end else if (rem_after == 16'h0) begin
                            if (!good_sent_r) begin
                                o_cmd_done <= 1'b1;
                                o_cmd_status <= `DBC_STAT_GOOD;
                            end
                            state_r <= dbc_pkg::DBC_ST_IDLE;
                        end else begin
                            // next chunk wraps to segment start only after commit
                            rem_r <= rem_after;
                            cur_lba_r <= lba_after;
                            chunk_r <= chunk_next;
                            o_xfer_len <= chunk_next;
                            o_xfer_to_host <= 1'b0;
                            state_r <= dbc_pkg::DBC_ST_XFER_WR;
                        end
                    end
                end
                dbc_pkg::DBC_ST_SYNC: begin
                    if (!any_dirty) begin
                        o_cmd_done <= 1'b1;
                        o_cmd_status <= `DBC_STAT_GOOD;
                        state_r <= dbc_pkg::DBC_ST_IDLE;
                    end
                end
                default: begin
                    state_r <= dbc_pkg::DBC_ST_IDLE;
                end
            endcase
            // deferred error set beats a same-cycle clear
            if (state_r == dbc_pkg::DBC_ST_MED_WR && i_med_done && i_med_err && good_sent_r) begin
                defer_r <= 1'b1;
            end
        end
    end
endmodule // dbc_cache_ctrl

// [verification/dbc_cache_ctrl_properties.sv]
// port checker for the buffer cache controller
`timescale 1ns/1ns
module dbc_chk (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // watched ports
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_cmd_done,
    input wire logic o_cmd_status,
    input wire logic o_med_req,
    input wire logic o_med_wr,
    input wire logic [31:0] o_med_lba,
    input wire logic i_med_done,
    input wire logic i_med_err,
    input wire logic o_xfer_req,
    input wire logic [15:0] o_xfer_len,
    input wire logic i_xfer_ratio_ok,
    input wire logic i_xfer_done,
    input wire logic o_deferred_err
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    logic seen_err_r;
    // a late error may surface long after the medium pulse
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) seen_err_r <= 1'b0;
        else if (o_med_req && i_med_done && i_med_err) seen_err_r <= 1'b1;
    end
    property p_segsize;
        $past(i_rd) && $past(i_addr) == 8'h08 |-> o_rdata == 32'h0000ffff;
    endproperty
    a_segsize: assert property (p_segsize) else $error("segment size not all ones");
    property p_done_pulse;
        o_cmd_done |=> !o_cmd_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    property p_med_hold;
        o_med_req && !i_med_done |=> o_med_req && $stable(o_med_lba) && $stable(o_med_wr);
    endproperty
    a_med_hold: assert property (p_med_hold) else $error("medium request changed early");
    property p_med_release;
        o_med_req && i_med_done |=> !o_med_req;
    endproperty
    a_med_release: assert property (p_med_release) else $error("medium request kept");
    property p_xfer_hold;
        o_xfer_req && !i_xfer_done |=> o_xfer_req && $stable(o_xfer_len);
    endproperty
    a_xfer_hold: assert property (p_xfer_hold) else $error("transfer request changed");
    property p_xfer_release;
        o_xfer_req && i_xfer_done |=> !o_xfer_req;
    endproperty
    a_xfer_release: assert property (p_xfer_release) else $error("transfer kept");
    property p_xfer_ratio;
        $rose(o_xfer_req) |-> $past(i_xfer_ratio_ok);
    endproperty
    a_xfer_ratio: assert property (p_xfer_ratio) else $error("transfer without ratio");
    property p_deferred;
        $rose(o_deferred_err) |-> seen_err_r;
    endproperty
    a_deferred: assert property (p_deferred) else $error("deferred error without cause");
    c_defer: cover property (o_deferred_err);
    c_check: cover property (o_cmd_done && o_cmd_status);
    c_med_wr: cover property (o_med_req && o_med_wr);
endmodule // dbc_chk
bind dbc_cache_ctrl dbc_chk dbc_chk_i (.i_clock, .i_rst_b, .i_addr, .i_rd, .o_rdata,
    .o_cmd_done, .o_cmd_status, .o_med_req, .o_med_wr, .o_med_lba, .i_med_done,
    .i_med_err, .o_xfer_req, .o_xfer_len, .i_xfer_ratio_ok, .i_xfer_done, .o_deferred_err);

// [verification/dbc_far_model.sv]
// medium engine and host link responder
`timescale 1ns/1ns
module dbc_far_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // bench controls
    input wire logic [3:0] i_lat,
    input wire logic i_err_on,
    input wire logic i_slow,
    // requests
    input wire logic i_med_req,
    input wire logic i_xfer_req,
    // answers
    output logic o_med_done,
    output logic o_med_err,
    output logic o_xfer_done,
    output logic o_ratio_ok
);
    logic [3:0] med_cnt_r;
    logic [3:0] xfer_cnt_r;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {o_med_done, o_med_err, o_xfer_done, o_ratio_ok} <= 4'h0;
            med_cnt_r <= 4'h0;
            xfer_cnt_r <= 4'h0;
        end else begin
            o_med_done <= 1'b0;
            o_xfer_done <= 1'b0;
            // error line means nothing away from done, so it wanders
            o_med_err <= ~o_med_err;
            o_ratio_ok <= i_slow ? ~o_ratio_ok : 1'b1;
            if (i_med_req && !o_med_done) begin
                med_cnt_r <= med_cnt_r + 4'h1;
                if (med_cnt_r >= i_lat) begin
                    o_med_done <= 1'b1;
                    o_med_err <= i_err_on;
                    med_cnt_r <= 4'h0;
                end
            end
            if (i_xfer_req && !o_xfer_done) begin
                xfer_cnt_r <= xfer_cnt_r + 4'h1;
                if (xfer_cnt_r >= i_lat) begin
                    o_xfer_done <= 1'b1;
                    xfer_cnt_r <= 4'h0;
                end
            end
        end
    end
endmodule // dbc_far_model

// [verification/test_dbc_cache_ctrl.sv]
// self-checking bench for the buffer cache controller
`timescale 1ns/1ns
module test_dbc_cache_ctrl;
    logic i_clock, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_cmd_valid = 1'b0;
    logic i_med_done, i_med_err, i_xfer_ratio_ok, i_xfer_done, err_on = 1'b0, slow = 1'b0;
    logic o_cmd_ready, o_cmd_done, o_cmd_status, o_med_req, o_med_wr, o_xfer_req;
    logic o_xfer_to_host, o_deferred_err;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, i_cmd_lba = 32'h0, o_rdata, o_med_lba, rv;
    logic [1:0] i_cmd_op = 2'h0;
    logic [15:0] i_cmd_len = 16'h0, o_med_len, o_xfer_len;
    logic [2:0] o_med_seg, o_xfer_seg;
    logic [3:0] lat = 4'h1;
    int errors, tests_run, cyc, med_rd, seed, pc, pend, chits, phits, read_cache_disable, rad, b;
    int qs[$], qe[$], qk[$];
    dbc_cache_ctrl #(.SEG_BLKS(16'h0004), .PF_BLKS(16'h0004)) dbc_cache_ctrl_i (.*);
    dbc_far_model dbc_far_model_i (.i_clock, .i_rst_b, .i_lat(lat), .i_err_on(err_on),
        .i_slow(slow), .i_med_req(o_med_req), .i_xfer_req(o_xfer_req),
        .o_med_done(i_med_done), .o_med_err(i_med_err), .o_xfer_done(i_xfer_done),
        .o_ratio_ok(i_xfer_ratio_ok));
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (o_med_req && !o_med_wr && i_med_done) med_rd <= med_rd + 1;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        if (a == 8'h00) {rad, read_cache_disable} = {int'(d[2]), int'(d[0])};
        @(posedge i_clock);
        {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge i_clock);
        {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        rv = o_rdata;
    endtask
    task automatic push(input int s, input int e, input int k);
        qs.push_back(s);
        qe.push_back(e);
        qk.push_back(k);
    endtask
    // reference: 0 miss, 1 cache hit, 2 prefetch hit
    function automatic int look(input int s, input int e);
        look = 0;
        foreach (qs[k]) if (s >= qs[k] && e <= qe[k] && (qk[k] || !read_cache_disable)) look = qk[k] + 1;
    endfunction
    task automatic cmd(input logic [1:0] op, input int s, input int n, input logic st);
        int h;
        int c0;
        h = (op == 2'h0) ? look(s, s + n) : 1;
        @(posedge i_clock);
        {i_cmd_valid, i_cmd_op, i_cmd_lba, i_cmd_len} <= {1'b1, op, s, n[15:0]};
        lat <= 4'($random(seed));
        slow <= 1'($random(seed));
        do @(negedge i_clock); while (o_cmd_ready !== 1'b1);
        c0 = med_rd;
        @(posedge i_clock);
        i_cmd_valid <= 1'b0;
        do @(negedge i_clock); while (o_cmd_done !== 1'b1);
        chk(o_cmd_status, st);
        chk(med_rd - c0, h ? 0 : 1);
        if (op == 2'h0) begin
            chits += (h == 1);
            phits += (h == 2);
            if (!h && !read_cache_disable) push(s, s + n, 0);
            pc = (s == pend) ? (pc < 3 ? pc + 1 : 3) : (pc > 0 ? pc - 1 : 0);
            pend = s + n;
            if (!rad && pc >= 2) push(pend, pend + 4, 1);
        end else if (op == 2'h1) begin
            for (int k = qs.size() - 1; k >= 0; k--) if (s < qe[k] && s + n > qs[k]) begin
                qs.delete(k);
                qe.delete(k);
                qk.delete(k);
            end
            if (!read_cache_disable) push(s, s + n, 0);
        end
    endtask
    initial begin
        seed = 32'h7112e15b;
        repeat (10) @(posedge i_clock);
        i_rst_b <= 1'b1;
        b = ($random(seed) & 32'h00ff_fff0) + 32'h100;
        rreg(8'h00); chk(rv, 32'h0);
        rreg(8'h3c); chk(rv, 32'h0);
        wreg(8'h08, 32'h5); rreg(8'h04); chk(rv[1], 1'b0);
        wreg(8'h00, 32'h8); wreg(8'h08, 32'h5); rreg(8'h04); chk(rv[1], 1'b1);
        rreg(8'h08); chk(rv, 32'h0000ffff);
        wreg(8'h14, 32'h2); rreg(8'h04); chk(rv[1], 1'b0);
        wreg(8'h00, 32'h4);
        cmd(2'h0, b, 4, 1'b0);
        cmd(2'h0, b, 4, 1'b0);
        cmd(2'h0, b + 1, 4, 1'b0);
        cmd(2'h1, b + 2, 2, 1'b0);
        cmd(2'h0, b, 2, 1'b0);
        cmd(2'h0, b + 2, 2, 1'b0);
        wreg(8'h00, 32'h5);
        repeat (2) cmd(2'h0, b + 2, 2, 1'b0);
        wreg(8'h00, 32'h0);
        for (int k = 0; k < 4; k++) cmd(2'h0, b + 64 + 4 * k, 4, 1'b0);
        wreg(8'h00, 32'h6);
        cmd(2'h1, b + 256, 6, 1'b0);
        err_on <= 1'b1;
        cmd(2'h1, b + 256, 4, 1'b0);
        for (int k = 0; k < 200 && o_deferred_err !== 1'b1; k++) @(negedge i_clock);
        chk(o_deferred_err, 1'b1);
        wreg(8'h14, 32'h1);
        wreg(8'h00, 32'h4);
        cmd(2'h1, b + 256, 2, 1'b1);
        err_on <= 1'b0;
        cmd(2'h2, 0, 1, 1'b0);
        rreg(8'h0c); chk(rv, chits);
        rreg(8'h10); chk(rv, phits);
        tally_and_finish();
    end
endmodule // test_dbc_cache_ctrl
